// *** core/spf_pkg.sv ***
// Shared constants and types for the serial peripheral block with queues
package spf_pkg;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_BAUD   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_QCTRL  = 8'h14;
  localparam logic [7:0] OFF_ICLR   = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int C1_LSB = 0, C1_SOE = 1, C1_CLOCK_PHASE_SEL = 2, C1_CLOCK_POLARITY_SEL = 3;
  localparam int C1_CONTROLLER_SELECT = 4, C1_TXIE = 5, C1_EN = 6, C1_RXIE = 7;
  localparam int C2_SWSEL = 0, C2_SWOE = 3, C2_FDE = 4, C2_W16 = 6;
  localparam int BR_DIV_LSB = 0, BR_PRE_LSB = 4;
  localparam int SB_TNE = 2, SB_RNF = 3, SB_MODE_FAULT_FLAG = 4, SB_TXE = 5, SB_RXF = 7;
  localparam int QC_QMODE = 0, QC_RNF_IEN = 1, QC_TNE_IEN = 2, QC_MANCLR = 3;
  localparam int QC_RNF_MARK = 4, QC_TNE_MARK = 5;
  localparam int IC_RXOVF = 4, IC_TXOVF = 5, IC_RXERR = 6, IC_TXERR = 7;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_BAUD  = 8'h00;
  localparam logic [7:0] RST_QCTRL = 8'h00;
  localparam logic [7:0] RST_ICLR  = 8'h00;
  localparam int         QUEUE_DEPTH = 8;
  localparam logic [3:0] QUEUE_LIMIT = 4'h8;
  localparam logic [3:0] CAP_WORDS16 = 4'h4;
  localparam logic [3:0] CAP_SINGLE  = 4'h1;
  localparam logic [4:0] TNE_MARK_LO = 5'h02;
  localparam logic [4:0] TNE_MARK_HI = 5'h04;
  localparam logic [4:0] RNF_MARK_LO = 5'h06;
  localparam logic [4:0] RNF_MARK_HI = 5'h04;
  localparam logic [3:0] DIV_MAX     = 4'h8;
  localparam logic [5:0] EDGES_8     = 6'h10;
  localparam logic [5:0] EDGES_16    = 6'h20;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    XS_IDLE  = 2'b00,
    XS_LEAD  = 2'b01,
    XS_XFER  = 2'b10,
    XS_TRAIL = 2'b11
  } spf_state_t;

endpackage

// *** core/spf_core.sv ***
// Serial peripheral unit with queues, master engine and AXI4-Lite registers
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module spf_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        select_n_in,
  output logic             select_n_out,
  output logic             select_n_oe,
  output logic             serial_clock_out,
  output logic             serial_clock_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  output logic             spi_irq
);

  // ****************************************
  // Helpers
  // ****************************************
  // Known register word; shared by read and write decode
  function automatic logic addr_known(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == spf_pkg::OFF_CTRL1) || (w == spf_pkg::OFF_CTRL2) || (w == spf_pkg::OFF_BAUD) ||
           (w == spf_pkg::OFF_STATUS) || (w == spf_pkg::OFF_DATA) || (w == spf_pkg::OFF_QCTRL) ||
           (w == spf_pkg::OFF_ICLR);
  endfunction

  function automatic logic [15:0] shift_in(input logic [15:0] s, input logic b, input logic lsb,
                                           input logic w16);
    logic [15:0] r;
    r = {s[14:0], b};
    if (lsb && w16) begin
      r = {b, s[15:1]};
    end else if (lsb) begin
      r = {8'h00, b, s[7:1]};
    end
    return r;
  endfunction

  function automatic logic out_bit(input logic [15:0] s, input logic lsb, input logic w16);
    return lsb ? s[0] : (w16 ? s[15] : s[7]);
  endfunction

  // ****************************************
  // Registers and decoded controls
  // ****************************************
  logic [7:0]  ctrl1_ff, ctrl2_ff, baud_ff, qctrl_ff;
  logic        mode_fault_flag_ff, mode_fault_flag_armed_ff;
  logic        tx_ovf_ff, rx_ovf_ff, tx_err_ff, rx_err_ff;
  logic [3:0]  pend_ff, flag_prev_ff;
  logic [16:0] cfg_prev_ff;
  logic [2:0]  sy1_ff, sy2_ff;
  logic [7:0]  aw_addr_ff, rd_addr;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;

  wire serial_enable        = ctrl1_ff[spf_pkg::C1_EN];
  wire controller_select    = ctrl1_ff[spf_pkg::C1_CONTROLLER_SELECT];
  wire clock_polarity_sel   = ctrl1_ff[spf_pkg::C1_CLOCK_POLARITY_SEL];
  wire clock_phase_sel      = ctrl1_ff[spf_pkg::C1_CLOCK_PHASE_SEL];
  wire select_output_enable = ctrl1_ff[spf_pkg::C1_SOE];
  wire lsb_first_select     = ctrl1_ff[spf_pkg::C1_LSB];
  wire rx_fault_irq_enable  = ctrl1_ff[spf_pkg::C1_RXIE];
  wire tx_irq_enable        = ctrl1_ff[spf_pkg::C1_TXIE];
  wire fault_detect_enable  = ctrl2_ff[spf_pkg::C2_FDE];
  wire single_wire_select   = ctrl2_ff[spf_pkg::C2_SWSEL];
  wire single_wire_output_enable = ctrl2_ff[spf_pkg::C2_SWOE];
  wire word_length_select   = ctrl2_ff[spf_pkg::C2_W16];
  wire queue_mode_enable    = qctrl_ff[spf_pkg::QC_QMODE];
  wire manual_irq_clear_select = qctrl_ff[spf_pkg::QC_MANCLR];
  wire [2:0] rate_prescale_bits = baud_ff[spf_pkg::BR_PRE_LSB +: 3];
  wire [3:0] rate_divisor_bits  = baud_ff[spf_pkg::BR_DIV_LSB +: 4];

  // Synchronised pins: [0] select, [1] mosi, [2] miso; only stage two is read
  wire ss_s   = sy2_ff[0];
  wire rx_pin = single_wire_select ? sy2_ff[1] : sy2_ff[2];
  wire master_on = serial_enable && controller_select;

  // ****************************************
  // Bus handshake terms
  // ****************************************
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire [7:0] wr_word = {aw_addr_ff[7:2], 2'b00};
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire wr_ok = wr_go && addr_known(aw_addr_ff) && w_strb_ff[0];
  wire wr_c1 = wr_ok && (wr_word == spf_pkg::OFF_CTRL1);
  wire rd_st = rd_go && (rd_addr == spf_pkg::OFF_STATUS);
  wire rd_ic = rd_go && (rd_addr == spf_pkg::OFF_ICLR);

  // ****************************************
  // Queues
  // ****************************************
  logic [15:0] tq_mem [spf_pkg::QUEUE_DEPTH];
  logic [15:0] rq_mem [spf_pkg::QUEUE_DEPTH];
  logic [2:0]  tw_ff, tr_ff, rw_ff, rr_ff;
  logic [3:0]  tcnt_ff, rcnt_ff;
  logic [15:0] rx_word_ff;
  logic        done_ff;
  spf_pkg::spf_state_t st_ff;

  // One-entry buffers unless queue mode; word mode halves the byte queue
  wire [3:0] cap = queue_mode_enable ? (word_length_select ? spf_pkg::CAP_WORDS16 : spf_pkg::QUEUE_LIMIT)
                                     : spf_pkg::CAP_SINGLE;
  wire tx_err = tcnt_ff > spf_pkg::QUEUE_LIMIT;
  wire rx_err = rcnt_ff > spf_pkg::QUEUE_LIMIT;
  wire tx_req = wr_ok && (wr_word == spf_pkg::OFF_DATA);
  wire tx_push = tx_req && (tcnt_ff < cap);
  wire tx_ovf  = tx_req && !(tcnt_ff < cap) && queue_mode_enable;
  wire rx_push = done_ff && (rcnt_ff < cap);
  wire rx_ovf  = done_ff && !(rcnt_ff < cap) && queue_mode_enable;
  wire rx_pop  = rd_go && (rd_addr == spf_pkg::OFF_DATA) && (rcnt_ff != 4'h0);
  wire [15:0] tx_word = {(word_length_select && w_strb_ff[1]) ? w_data_ff[15:8] : 8'h00, w_data_ff[7:0]};

  // Reconfiguration watch: any change here while master aborts the transfer
  wire [16:0] cfg_now = {clock_polarity_sel, clock_phase_sel, select_output_enable, lsb_first_select,
                         fault_detect_enable, single_wire_select, single_wire_select && single_wire_output_enable,
                         word_length_select, queue_mode_enable, baud_ff};
  wire mode_fault_flag_evt = master_on && fault_detect_enable && !select_output_enable && !ss_s;
  wire abort = mode_fault_flag_evt || (controller_select && (cfg_now != cfg_prev_ff)) || !serial_enable;
  wire start = (st_ff == spf_pkg::XS_IDLE) && master_on && (tcnt_ff != 4'h0) && !abort;
  wire tx_pop = start;

  // Transmit queue storage and pointers; overflowing writes are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_err) begin
      tw_ff   <= 3'h0;
      tr_ff   <= 3'h0;
      tcnt_ff <= 4'h0;
    end else begin
      if (tx_push) begin
        tq_mem[tw_ff] <= tx_word;
        tw_ff         <= tw_ff + 3'h1;
      end
      if (tx_pop) begin
        tr_ff <= tr_ff + 3'h1;
      end
      tcnt_ff <= tcnt_ff + {3'h0, tx_push} - {3'h0, tx_pop};
    end
  end

  // Receive queue; a word arriving to a full queue is lost
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_err) begin
      rw_ff   <= 3'h0;
      rr_ff   <= 3'h0;
      rcnt_ff <= 4'h0;
    end else begin
      if (rx_push) begin
        rq_mem[rw_ff] <= rx_word_ff;
        rw_ff         <= rw_ff + 3'h1;
      end
      if (rx_pop) begin
        rr_ff <= rr_ff + 3'h1;
      end
      rcnt_ff <= rcnt_ff + {3'h0, rx_push} - {3'h0, rx_pop};
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  wire [4:0] tx_bytes = word_length_select ? {tcnt_ff, 1'b0} : {1'b0, tcnt_ff};
  wire [4:0] rx_bytes = word_length_select ? {rcnt_ff, 1'b0} : {1'b0, rcnt_ff};
  wire rx_buffer_full_flag  = rcnt_ff != 4'h0;
  wire tx_buffer_empty_flag = tcnt_ff == 4'h0;
  wire tx_nearly_empty_flag = queue_mode_enable &&
       (tx_bytes <= (qctrl_ff[spf_pkg::QC_TNE_MARK] ? spf_pkg::TNE_MARK_HI : spf_pkg::TNE_MARK_LO));
  wire rx_nearly_full_flag = queue_mode_enable &&
       (rx_bytes >= (qctrl_ff[spf_pkg::QC_RNF_MARK] ? spf_pkg::RNF_MARK_HI : spf_pkg::RNF_MARK_LO));
  wire [3:0] flags = {tx_nearly_empty_flag, rx_nearly_full_flag, tx_buffer_empty_flag, rx_buffer_full_flag};
  wire [3:0] ien   = {tx_irq_enable && qctrl_ff[spf_pkg::QC_TNE_IEN] && queue_mode_enable,
                      rx_fault_irq_enable && qctrl_ff[spf_pkg::QC_RNF_IEN] && queue_mode_enable,
                      tx_irq_enable, rx_fault_irq_enable};

  // ****************************************
  // Control registers
  // ****************************************
  // Fault clears master select over any software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_ff <= spf_pkg::RST_CTRL1;
      ctrl2_ff <= spf_pkg::RST_CTRL2;
      baud_ff  <= spf_pkg::RST_BAUD;
      qctrl_ff <= spf_pkg::RST_QCTRL;
    end else begin
      if (wr_c1) begin
        ctrl1_ff <= w_data_ff[7:0];
      end
      if (wr_ok && (wr_word == spf_pkg::OFF_CTRL2)) begin
        ctrl2_ff <= w_data_ff[7:0];
      end
      if (wr_ok && (wr_word == spf_pkg::OFF_BAUD)) begin
        baud_ff <= {1'b0, w_data_ff[6:0]};
      end
      if (wr_ok && (wr_word == spf_pkg::OFF_QCTRL)) begin
        qctrl_ff <= {2'b00, w_data_ff[5:0]};
      end
      if (mode_fault_flag_evt) begin
        ctrl1_ff[spf_pkg::C1_CONTROLLER_SELECT] <= 1'b0;
      end
    end
  end

  // Mode fault flag: cleared by status read then control write; a new fault wins
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_err || rx_err) begin
      mode_fault_flag_ff       <= 1'b0;
      mode_fault_flag_armed_ff <= 1'b0;
    end else begin
      if (rd_st && mode_fault_flag_ff) begin
        mode_fault_flag_armed_ff <= 1'b1;
      end else if (wr_c1) begin
        mode_fault_flag_armed_ff <= 1'b0;
      end
      if (mode_fault_flag_evt) begin
        mode_fault_flag_ff <= 1'b1;
      end else if (wr_c1 && mode_fault_flag_armed_ff) begin
        mode_fault_flag_ff <= 1'b0;
      end
    end
  end

  // Overflow and error flags; a read clears only what it saw, new events win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {tx_err_ff, rx_err_ff, tx_ovf_ff, rx_ovf_ff} <= spf_pkg::RST_ICLR[7:4];
    end else begin
      tx_ovf_ff <= tx_ovf || (tx_ovf_ff && !rd_ic);
      rx_ovf_ff <= rx_ovf || (rx_ovf_ff && !rd_ic);
      tx_err_ff <= tx_err || (tx_err_ff && !rd_ic);
      rx_err_ff <= rx_err || (rx_err_ff && !rd_ic);
    end
  end

  // Interrupt request; manual mode latches flag rises until write-one clear
  wire [3:0] clr_bits = (wr_ok && (wr_word == spf_pkg::OFF_ICLR) && manual_irq_clear_select)
                        ? w_data_ff[3:0] : 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff      <= 4'h0;
      flag_prev_ff <= 4'h0;
      spi_irq      <= 1'b0;
    end else begin
      flag_prev_ff <= flags;
      pend_ff      <= (pend_ff & ~clr_bits) | (flags & ~flag_prev_ff);
      spi_irq      <= (|((manual_irq_clear_select ? pend_ff : flags) & ien)) ||
                      (mode_fault_flag_ff && rx_fault_irq_enable);
    end
  end

  // ****************************************
  // Master transfer engine
  // ****************************************
  logic [11:0] bcnt_ff;
  logic [5:0]  eidx_ff;
  logic [15:0] sh_ff;
  logic        rxb_ff, sck_lvl_ff;

  wire [3:0]  div_eff  = (rate_divisor_bits > spf_pkg::DIV_MAX) ? spf_pkg::DIV_MAX : rate_divisor_bits;
  wire [11:0] half_cyc = 12'({8'h00, 1'b0, rate_prescale_bits} + 12'h001) << div_eff;
  wire        tick     = bcnt_ff == (half_cyc - 12'h001);
  wire [5:0]  nedges   = word_length_select ? spf_pkg::EDGES_16 : spf_pkg::EDGES_8;
  wire [5:0]  e_num    = eidx_ff + 6'h01;
  wire        edge_now = tick && ((st_ff == spf_pkg::XS_LEAD) || (st_ff == spf_pkg::XS_XFER));
  wire        samp     = e_num[0] ^ clock_phase_sel;
  wire        do_shift = edge_now && !samp && !(clock_phase_sel && (e_num == 6'h01));
  wire [15:0] sh_fin   = clock_phase_sel ? shift_in(sh_ff, rxb_ff, lsb_first_select, word_length_select) : sh_ff;

  // Half-period timer; idle holds it at zero so the lead delay is exact
  always_ff @(posedge aclk) begin
    if (!aresetn || (st_ff == spf_pkg::XS_IDLE) || tick) begin
      bcnt_ff <= 12'h000;
    end else begin
      bcnt_ff <= bcnt_ff + 12'h001;
    end
  end

  // Sequencer: lead half period, 2n edges, trailing half period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff      <= spf_pkg::XS_IDLE;
      eidx_ff    <= 6'h00;
      sck_lvl_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (abort) begin
        st_ff      <= spf_pkg::XS_IDLE;
        sck_lvl_ff <= 1'b0;
      end else begin
        unique case (st_ff)
          spf_pkg::XS_IDLE: begin
            eidx_ff <= 6'h00;
            if (start) begin
              st_ff <= spf_pkg::XS_LEAD;
            end
          end
          spf_pkg::XS_LEAD, spf_pkg::XS_XFER: begin
            if (tick) begin
              eidx_ff    <= e_num;
              sck_lvl_ff <= ~sck_lvl_ff;
              st_ff      <= (e_num == nedges) ? spf_pkg::XS_TRAIL : spf_pkg::XS_XFER;
            end
          end
          spf_pkg::XS_TRAIL: begin
            if (tick) begin
              st_ff   <= spf_pkg::XS_IDLE;
              done_ff <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Shifter: load on start, sample and shift on alternate edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_ff      <= 16'h0000;
      rxb_ff     <= 1'b0;
      rx_word_ff <= 16'h0000;
    end else begin
      if (start) begin
        sh_ff <= tq_mem[tr_ff];
      end else if (do_shift) begin
        sh_ff <= shift_in(sh_ff, rxb_ff, lsb_first_select, word_length_select);
      end
      if (edge_now && samp) begin
        rxb_ff <= rx_pin;
      end
      if ((st_ff == spf_pkg::XS_TRAIL) && tick) begin
        rx_word_ff <= word_length_select ? sh_fin : {8'h00, sh_fin[7:0]};
      end
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // Two-stage synchronisers for pins arriving from outside this clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_ff      <= 3'h7;
      sy2_ff      <= 3'h7;
      cfg_prev_ff <= 17'h00000;
    end else begin
      sy1_ff      <= {miso_in, mosi_in, select_n_in};
      sy2_ff      <= sy1_ff;
      cfg_prev_ff <= cfg_now;
    end
  end

  // Pin drivers; target shifting is not built, so MISO stays released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_clock_out <= 1'b0;
      serial_clock_oe  <= 1'b0;
      mosi_out         <= 1'b0;
      mosi_oe          <= 1'b0;
      miso_out         <= 1'b0;
      miso_oe          <= 1'b0;
      select_n_out     <= 1'b1;
      select_n_oe      <= 1'b0;
    end else begin
      serial_clock_out <= clock_polarity_sel ^ sck_lvl_ff;
      serial_clock_oe  <= master_on;
      mosi_out         <= out_bit(sh_ff, lsb_first_select, word_length_select);
      mosi_oe          <= master_on && (!single_wire_select || single_wire_output_enable);
      miso_out         <= 1'b0;
      miso_oe          <= 1'b0;
      select_n_out     <= st_ff == spf_pkg::XS_IDLE;
      select_n_oe      <= master_on && fault_detect_enable && select_output_enable;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic [31:0] rd_val;

  // Read data select; clear bits always return zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (rd_addr)
      spf_pkg::OFF_CTRL1:  rd_val[7:0] = ctrl1_ff;
      spf_pkg::OFF_CTRL2:  rd_val[7:0] = ctrl2_ff;
      spf_pkg::OFF_BAUD:   rd_val[7:0] = baud_ff;
      spf_pkg::OFF_STATUS: begin
        rd_val[spf_pkg::SB_RXF]  = rx_buffer_full_flag;
        rd_val[spf_pkg::SB_TXE]  = tx_buffer_empty_flag;
        rd_val[spf_pkg::SB_MODE_FAULT_FLAG] = mode_fault_flag_ff;
        rd_val[spf_pkg::SB_RNF]  = rx_nearly_full_flag;
        rd_val[spf_pkg::SB_TNE]  = tx_nearly_empty_flag;
      end
      spf_pkg::OFF_DATA:   rd_val[15:0] = rx_buffer_full_flag ? rq_mem[rr_ff] : 16'h0000;
      spf_pkg::OFF_QCTRL:  rd_val[7:0] = qctrl_ff;
      spf_pkg::OFF_ICLR:   rd_val[7:0] = {tx_err_ff, rx_err_ff, tx_ovf_ff, rx_ovf_ff, 4'h0};
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // Write channels: address and data taken independently, answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= spf_pkg::RESP_OKAY;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(aw_addr_ff) ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= spf_pkg::RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= addr_known(s_axi_araddr) ? spf_pkg::RESP_OKAY : spf_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // spf_core

// *** bench/spf_props.sv ***
// Concurrent checks on the serial unit's pins and register reads
`timescale 1ns/1ns
module spf_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        select_n_out,
  input wire logic        select_n_oe,
  input wire logic        serial_clock_out,
  input wire logic        serial_clock_oe,
  input wire logic        miso_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read request taken at one address; data follows one cycle later
  sequence s_rd(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  property p_clr; s_rd(spf_pkg::OFF_ICLR) |=> s_axi_rdata[3:0] == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear bits read back set");
  property p_dat; s_rd(spf_pkg::OFF_DATA) |=> s_axi_rdata[31:16] == 16'h0; endproperty
  a_dat: assert property (p_dat) else $error("data upper half set");
  property p_lead; $fell(select_n_out) |-> $stable(serial_clock_out); endproperty
  a_lead: assert property (p_lead) else $error("clock moved with select");
  property p_idle; select_n_oe && select_n_out && $past(select_n_out) |-> $stable(serial_clock_out); endproperty
  a_idle: assert property (p_idle) else $error("clock moved while idle");
  property p_run; $changed(serial_clock_out) && select_n_oe |-> !$past(select_n_out); endproperty
  a_run: assert property (p_run) else $error("edge outside select low");
  property p_own; $changed(serial_clock_out) |-> serial_clock_oe || $past(serial_clock_oe); endproperty
  a_own: assert property (p_own) else $error("clock moved undriven");
  property p_miso; serial_clock_oe |-> !miso_oe; endproperty
  a_miso: assert property (p_miso) else $error("master drives miso");
  property p_pins; select_n_oe |-> serial_clock_oe; endproperty
  a_pins: assert property (p_pins) else $error("select without clock pin");
endmodule // spf_props
bind spf_core spf_props u_props (.*);

// *** bench/spf_target.sv ***
// Far-side stand-in: echoing target plus a rival master on select
`timescale 1ns/1ns
module spf_target (
  input  wire logic aclk,
  input  wire logic sel_n,
  input  wire logic sdi,
  input  wire logic grab,
  output logic      sdo,
  output logic      other_sel_n
);
  // Echo while selected; toggle when released so no stale bit looks valid
  initial sdo = 1'b0;
  always @(posedge aclk) sdo <= sel_n ? ~sdo : sdi;
  // Rival master pulls select low, else holds it high
  assign other_sel_n = ~grab;
endmodule // spf_target

// *** bench/testbench.sv ***
// Self-checking bench: registers, transfers, queues, aborts, faults
`timescale 1ns/1ns
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, grab = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr_q, br_q;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, spi_irq;
  logic        select_n_out, select_n_oe, serial_clock_out, serial_clock_oe;
  logic        mosi_out, mosi_oe, miso_out, miso_oe, tgt_sdo, other_sel_n;
  int          n_fail = 0, total_checks = 0;
  // Wire levels from each party's enable for select and MISO; MOSI follows mosi_out alone
  wire select_n_in = select_n_oe ? select_n_out : other_sel_n;
  wire mosi_in     = mosi_out;
  wire miso_in     = miso_oe ? miso_out : tgt_sdo;
  spf_core dut (.*);
  spf_target u_tgt (.aclk, .sel_n(select_n_in), .sdi(mosi_out), .grab, .sdo(tgt_sdo), .other_sel_n);
  always #2 aclk = ~aclk;
  // Write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        br_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
  endtask
  // Read: data and response kept at the handshake edge
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_q = s_axi_rdata;
        rr_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_arvalid | s_axi_rready);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_q & m, e);
  endtask
  // Bounded poll until a masked bit shows up
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    rd(a);
    for (int i = 0; i < 1000 && (rd_q & m) == 0; i++)
      rd(a);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence; half period of the link is 10 cycles, 80 ns per bit
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      if (i != 3) rc(8'(i * 4), 32'hff, 32'h0);
    rd(8'h1c);
    chk({30'h0, rr_q}, {30'h0, spf_pkg::RESP_SLVERR});
    wr(8'h1c, 32'h0);
    chk({30'h0, br_q}, {30'h0, spf_pkg::RESP_SLVERR});
    wr(spf_pkg::OFF_ICLR, 32'h0f);
    chk({30'h0, br_q}, {30'h0, spf_pkg::RESP_OKAY});
    rc(spf_pkg::OFF_ICLR, 32'hff, 32'h0);
    wr(spf_pkg::OFF_BAUD, 32'h41);
    wr(spf_pkg::OFF_CTRL2, 32'h10);
    wr(spf_pkg::OFF_CTRL1, 32'h52);
    rc(spf_pkg::OFF_STATUS, 32'h20, 32'h20);
    wr(spf_pkg::OFF_DATA, 32'ha5);
    poll(spf_pkg::OFF_STATUS, 32'h80);
    rc(spf_pkg::OFF_DATA, 32'hffffffff, 32'ha5);
    // Manual clearing: a clear written before selecting it must not stick
    wr(spf_pkg::OFF_ICLR, 32'h02);
    wr(spf_pkg::OFF_QCTRL, 32'h08);
    wr(spf_pkg::OFF_CTRL1, 32'h72);
    chk({31'h0, spi_irq}, 32'h1);
    wr(spf_pkg::OFF_ICLR, 32'h02);
    chk({31'h0, spi_irq}, 32'h0);
    // Second phase, LSB first; the echo must come back whole
    wr(spf_pkg::OFF_CTRL1, 32'h57);
    wr(spf_pkg::OFF_DATA, 32'h96);
    poll(spf_pkg::OFF_STATUS, 32'h80);
    rc(spf_pkg::OFF_DATA, 32'hffffffff, 32'h96);
    // Reconfigure mid-word, check select is released, then set the rate again
    wr(spf_pkg::OFF_DATA, 32'h3c);
    wr(spf_pkg::OFF_BAUD, 32'h42);
    repeat (3) @(posedge aclk);
    chk({31'h0, select_n_out}, 32'h1);
    wr(spf_pkg::OFF_BAUD, 32'h41);
    // Queue: ten writes, one in the shifter, eight queued, one too many
    wr(spf_pkg::OFF_QCTRL, 32'h01);
    for (int i = 0; i < 10; i++)
      wr(spf_pkg::OFF_DATA, 32'(i));
    rc(spf_pkg::OFF_ICLR, 32'hff, 32'h20);
    rc(spf_pkg::OFF_ICLR, 32'hff, 32'h0);
    poll(spf_pkg::OFF_ICLR, 32'h10);
    chk(rd_q & 32'hff, 32'h10);
    for (int i = 0; i < 8; i++)
      rc(spf_pkg::OFF_DATA, 32'hff, 32'(i));
    // Rival master grabs select while fault detection is armed
    wr(spf_pkg::OFF_CTRL1, 32'hd0);
    grab <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({31'h0, spi_irq}, 32'h1);
    chk({31'h0, serial_clock_oe}, 32'h0);
    rc(spf_pkg::OFF_STATUS, 32'h10, 32'h10);
    rc(spf_pkg::OFF_CTRL1, 32'h10, 32'h0);
    grab <= 1'b0;
    summarize;
  end
  // Watchdog well past the expected few thousand cycles
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
endmodule // testbench
